// ==== shared/holdover_pkg.sv ====
// constants, field layout and types for the holdover / slope limit block
// Operation
// - the per-update output phase step is limited to a 31-bit unsigned magnitude, reset all ones.
// - the loop integrator is clamped to a 31-bit unsigned magnitude (full scale about 244 ppm).
// - holdover filter coefficient is 2^-(33-shift) times gain/4, bandwidth coe*f/(2*pi).
// - a zero coefficient bypasses the holdover filter.
// - a 2-bit source select picks instantaneous, history instant, manual or history average.
// - span n averages the frequency over the n+1 seconds before holdover entry.
// - manual mode outputs the 42-bit two's complement manual frequency word.
// - the divider fractional residue is scaled to converter resolution and added to the error.
// - separate 14-bit residue scale factors per reference input, both reset 0x23.
// - the filters assume a 562.5 kHz update rate and scale with the actual update strobe.
package holdover_pkg;
  // ==========================================================================
  // register byte addresses
  localparam logic [15:0] ADDR_SLOPE = 16'h01cc;
  localparam logic [15:0] ADDR_PULL = 16'h01d0;
  localparam logic [15:0] ADDR_FILT = 16'h01d4;
  localparam logic [15:0] ADDR_MODE = 16'h01d5;
  localparam logic [15:0] ADDR_MANUAL = 16'h01d6;
  localparam logic [15:0] ADDR_SCALE0 = 16'h01dc;
  localparam logic [15:0] ADDR_SCALE1 = 16'h01de;
  localparam int LIMIT_BYTES = 4;
  localparam int MANUAL_BYTES = 6;
  localparam int SCALE_BYTES = 2;

  // ==========================================================================
  // field layout and reset values
  localparam int SHIFT_LSB = 3;
  localparam int MODE_LSB = 6;
  localparam logic [31:0] LIMIT_MASK = 32'h7fffffff;
  localparam logic [47:0] MANUAL_MASK = 48'h03ffffffffff;
  localparam logic [15:0] SCALE_MASK = 16'h3fff;
  localparam logic [31:0] SLOPE_RST = 32'h7fffffff;
  localparam logic [31:0] PULL_RST = 32'h7fffffff;
  localparam logic [4:0] SHIFT_RST = 5'h08;
  localparam logic [2:0] GAIN_RST = 3'h4;
  localparam logic [5:0] SPAN_RST = 6'h00;
  localparam logic [47:0] MANUAL_RST = 48'h0;
  localparam logic [15:0] SCALE_RST = 16'h0023;

  // ==========================================================================
  // datapath scaling
  localparam int FREQ_W = 42;
  localparam int ERR_W = 24;
  localparam int PHASE_W = 32;
  localparam int SUM_W = 48;
  localparam int SPAN_W = 6;
  localparam int HIST_DEPTH = 64;
  localparam int COE_EXP_BASE = 33;
  localparam int COE_GAIN_LOG2 = 2;
  localparam int FILT_FRAC = COE_EXP_BASE + COE_GAIN_LOG2;
  localparam int ACC_W = FREQ_W + FILT_FRAC + 2;
  localparam int DENOMINATOR_WIDTH = 24;
  localparam int INTEG_TO_FREQ = 10;
  localparam int FREQ_TO_PHASE = 10;
  localparam real UPDATE_RATE_KHZ = 562.5;

  typedef enum logic [1:0] {
    SRC_INSTANT = 2'b00,
    SRC_HIST_INSTANT = 2'b01,
    SRC_MANUAL = 2'b10,
    SRC_HIST_AVG = 2'b11
  } source_t;

  typedef enum logic [1:0] {
    ST_TRACK = 2'b00,
    ST_SUM = 2'b01,
    ST_DIVIDE = 2'b11,
    ST_HOLD = 2'b10
  } hold_state_t;
endpackage

// ==== shared/divide_if.sv ====
// request / answer bundle between holdover logic and its averaging divider
`timescale 1ns/10ps
interface divide_if;
  logic start;
  logic signed [47:0] num;
  logic [6:0] den;
  logic done;
  logic signed [41:0] quot;
  modport requester (output start, output num, output den, input done, input quot);
  modport divider (input start, input num, input den, output done, output quot);
endinterface

// ==== rtl/average_divider.sv ====
// serial signed-by-unsigned divider for the history average
`timescale 1ns/10ps
module average_divider
  import holdover_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  divide_if.divider div
);
  logic [7:0] rem, next_rem;
  logic [SUM_W-1:0] quo, next_quo;
  logic [5:0] cnt, next_cnt;
  logic busy, next_busy;
  logic neg, next_neg;
  logic done, next_done;
  logic signed [FREQ_W-1:0] quot, next_quot;
  logic [7:0] rem_sh;

  // ==========================================================================
  // restoring division, one quotient bit a cycle
  always_comb begin
    next_rem = rem;
    next_quo = quo;
    next_cnt = cnt;
    next_busy = busy;
    next_neg = neg;
    next_done = 1'b0;
    next_quot = quot;
    rem_sh = {rem[6:0], quo[SUM_W-1]};
    if (div.start && !busy) begin
      next_neg = div.num[SUM_W-1];
      next_quo = div.num[SUM_W-1] ? -div.num : div.num;
      next_rem = 8'h00;
      next_cnt = 6'(SUM_W - 1);
      next_busy = 1'b1;
    end else if (busy) begin
      if (rem_sh >= {1'b0, div.den}) begin
        next_rem = rem_sh - {1'b0, div.den};
        next_quo = {quo[SUM_W-2:0], 1'b1};
      end else begin
        next_rem = rem_sh;
        next_quo = {quo[SUM_W-2:0], 1'b0};
      end
      next_cnt = cnt - 6'h01;
      if (cnt == 6'h00) begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_quot = neg ? -$signed(next_quo[FREQ_W-1:0]) : $signed(next_quo[FREQ_W-1:0]);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rem <= 8'h00;
      quo <= '0;
      cnt <= 6'h00;
      busy <= 1'b0;
      neg <= 1'b0;
      done <= 1'b0;
      quot <= '0;
    end else begin
      rem <= next_rem;
      quo <= next_quo;
      cnt <= next_cnt;
      busy <= next_busy;
      neg <= next_neg;
      done <= next_done;
      quot <= next_quot;
    end
  end

  assign div.done = done;
  assign div.quot = quot;
endmodule

// ==== rtl/holdover_slope_limit.sv ====
// second loop filter tail: residue cancel, integrator clamp, holdover, phase slope limit
`timescale 1ns/10ps
module holdover_slope_limit
  import holdover_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  output logic [7:0] reg_rdata,
  input wire logic upd_tick,
  input wire logic sec_tick,
  input wire logic holdover,
  input wire logic ref_sel,
  input wire logic signed [ERR_W-1:0] meas_err,
  input wire logic [DENOMINATOR_WIDTH-1:0] frac_residue,
  output logic signed [ERR_W-1:0] corrected_err,
  output logic signed [FREQ_W-1:0] freq_out,
  output logic signed [PHASE_W-1:0] phase_step,
  output logic holdover_ready
);
  // ==========================================================================
  // register file
  logic [31:0] phase_slope_max, next_slope;
  logic [31:0] pull_in_range_max, next_pull;
  logic [4:0] holdover_filter_shift, next_shift;
  logic [2:0] holdover_filter_gain, next_gain;
  source_t holdover_source_select, next_source;
  logic [5:0] holdover_average_span, next_span;
  logic [47:0] manual_holdover_freq, next_manual;
  logic [15:0] residue_scale_input0, next_scale0;
  logic [15:0] residue_scale_input1, next_scale1;
  logic [7:0] next_rdata;

  always_comb begin
    next_slope = phase_slope_max;
    next_pull = pull_in_range_max;
    next_shift = holdover_filter_shift;
    next_gain = holdover_filter_gain;
    next_source = holdover_source_select;
    next_span = holdover_average_span;
    next_manual = manual_holdover_freq;
    next_scale0 = residue_scale_input0;
    next_scale1 = residue_scale_input1;
    next_rdata = 8'h00;
    // one loop per register width keeps every byte select inside its field
    for (int i = 0; i < LIMIT_BYTES; i++) begin
      if (reg_addr == ADDR_SLOPE + 16'(i)) begin
        next_rdata = phase_slope_max[8*i +: 8];
        if (reg_wr) next_slope[8*i +: 8] = reg_wdata;
      end
      if (reg_addr == ADDR_PULL + 16'(i)) begin
        next_rdata = pull_in_range_max[8*i +: 8];
        if (reg_wr) next_pull[8*i +: 8] = reg_wdata;
      end
    end
    for (int i = 0; i < MANUAL_BYTES; i++) begin
      if (reg_addr == ADDR_MANUAL + 16'(i)) begin
        next_rdata = manual_holdover_freq[8*i +: 8];
        if (reg_wr) next_manual[8*i +: 8] = reg_wdata;
      end
    end
    for (int i = 0; i < SCALE_BYTES; i++) begin
      if (reg_addr == ADDR_SCALE0 + 16'(i)) begin
        next_rdata = residue_scale_input0[8*i +: 8];
        if (reg_wr) next_scale0[8*i +: 8] = reg_wdata;
      end
      if (reg_addr == ADDR_SCALE1 + 16'(i)) begin
        next_rdata = residue_scale_input1[8*i +: 8];
        if (reg_wr) next_scale1[8*i +: 8] = reg_wdata;
      end
    end
    if (reg_addr == ADDR_FILT) begin
      next_rdata = {holdover_filter_shift, holdover_filter_gain};
      if (reg_wr) begin
        next_shift = reg_wdata[7:SHIFT_LSB];
        next_gain = reg_wdata[SHIFT_LSB-1:0];
      end
    end
    if (reg_addr == ADDR_MODE) begin
      next_rdata = {holdover_source_select, holdover_average_span};
      if (reg_wr) begin
        next_source = source_t'(reg_wdata[7:MODE_LSB]);
        next_span = reg_wdata[MODE_LSB-1:0];
      end
    end
    // reserved bits never store, so they read back as zero
    next_slope = next_slope & LIMIT_MASK;
    next_pull = next_pull & LIMIT_MASK;
    next_manual = next_manual & MANUAL_MASK;
    next_scale0 = next_scale0 & SCALE_MASK;
    next_scale1 = next_scale1 & SCALE_MASK;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_slope_max <= SLOPE_RST;
      pull_in_range_max <= PULL_RST;
      holdover_filter_shift <= SHIFT_RST;
      holdover_filter_gain <= GAIN_RST;
      holdover_source_select <= SRC_INSTANT;
      holdover_average_span <= SPAN_RST;
      manual_holdover_freq <= MANUAL_RST;
      residue_scale_input0 <= SCALE_RST;
      residue_scale_input1 <= SCALE_RST;
      reg_rdata <= 8'h00;
    end else begin
      phase_slope_max <= next_slope;
      pull_in_range_max <= next_pull;
      holdover_filter_shift <= next_shift;
      holdover_filter_gain <= next_gain;
      holdover_source_select <= next_source;
      holdover_average_span <= next_span;
      manual_holdover_freq <= next_manual;
      residue_scale_input0 <= next_scale0;
      residue_scale_input1 <= next_scale1;
      reg_rdata <= next_rdata;
    end
  end

  // ==========================================================================
  // loop datapath, advanced once per update strobe
  logic signed [ERR_W-1:0] next_err;
  logic signed [FREQ_W-1:0] integ, next_integ;
  logic signed [ACC_W-1:0] filt_acc, next_filt_acc;
  logic signed [PHASE_W-1:0] next_phase;
  logic signed [FREQ_W-1:0] next_freq_out;
  logic [DENOMINATOR_WIDTH+13:0] residue_prod;
  logic signed [FREQ_W:0] integ_sum, integ_lim;
  logic signed [ACC_W:0] filt_diff;
  logic signed [ACC_W+3:0] filt_step;
  logic signed [FREQ_W-1:0] filt_word, ho_word;
  logic signed [PHASE_W:0] phase_raw, slope_lim;
  logic [5:0] coe_shift;

  always_comb begin
    // the scale already folds in 2^24 / denominator, so dropping 24 bits lands on steps
    residue_prod = frac_residue * (ref_sel ? residue_scale_input1[13:0]
                                           : residue_scale_input0[13:0]);
    next_err = corrected_err;
    next_integ = integ;
    next_filt_acc = filt_acc;
    next_phase = phase_step;
    filt_word = filt_acc[ACC_W-3 -: FREQ_W];
    integ_lim = (FREQ_W+1)'({pull_in_range_max[30:0], {INTEG_TO_FREQ{1'b0}}});
    integ_sum = (FREQ_W+1)'(integ) + (FREQ_W+1)'(corrected_err);
    coe_shift = 6'(FILT_FRAC) - 6'(holdover_filter_shift);
    filt_diff = (ACC_W+1)'($signed({integ, {FILT_FRAC{1'b0}}})) - (ACC_W+1)'(filt_acc);
    filt_step = ((ACC_W+4)'(filt_diff) * $signed({1'b0, holdover_filter_gain}))
                >>> coe_shift;
    phase_raw = (PHASE_W+1)'(corrected_err) + (PHASE_W+1)'(freq_out >>> FREQ_TO_PHASE);
    slope_lim = (PHASE_W+1)'({1'b0, phase_slope_max[30:0]});
    if (upd_tick) begin
      next_err = meas_err + ERR_W'(residue_prod >> DENOMINATOR_WIDTH);
      if (!holdover) begin
        // loop open in holdover: integrator and filter keep the entry value
        if (integ_sum > integ_lim)
          next_integ = FREQ_W'(integ_lim);
        else if (integ_sum < -integ_lim)
          next_integ = FREQ_W'(-integ_lim);
        else
          next_integ = FREQ_W'(integ_sum);
        if (holdover_filter_gain == 3'h0)
          next_filt_acc = ACC_W'($signed({next_integ, {FILT_FRAC{1'b0}}}));
        else
          next_filt_acc = filt_acc + ACC_W'(filt_step);
      end
      if (phase_raw > slope_lim)
        next_phase = PHASE_W'(slope_lim);
      else if (phase_raw < -slope_lim)
        next_phase = PHASE_W'(-slope_lim);
      else
        next_phase = PHASE_W'(phase_raw);
    end
    next_freq_out = holdover ? ho_word : integ;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      corrected_err <= '0;
      integ <= '0;
      filt_acc <= '0;
      phase_step <= '0;
      freq_out <= '0;
    end else begin
      corrected_err <= next_err;
      integ <= next_integ;
      filt_acc <= next_filt_acc;
      phase_step <= next_phase;
      freq_out <= next_freq_out;
    end
  end

  // ==========================================================================
  // one-second history and holdover entry
  logic signed [FREQ_W-1:0] history [HIST_DEPTH];
  logic [SPAN_W-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr, cnt, next_cnt;
  logic signed [SUM_W-1:0] sum, next_sum;
  logic signed [FREQ_W-1:0] next_ho_word;
  hold_state_t state, next_state;
  logic hist_we, start, next_start;
  divide_if div ();

  average_divider u_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .div(div)
  );

  assign div.start = start;
  assign div.num = sum;
  assign div.den = 7'(holdover_average_span) + 7'h01;
  assign holdover_ready = (state == ST_HOLD);

  always_comb begin
    next_state = state;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_cnt = cnt;
    next_sum = sum;
    next_ho_word = ho_word;
    next_start = 1'b0;
    hist_we = sec_tick && !holdover;
    if (hist_we) next_wr_ptr = wr_ptr + 6'h01;
    unique case (state)
      ST_TRACK: begin
        if (holdover) begin
          next_ho_word = filt_word;
          next_state = ST_HOLD;
          if (holdover_source_select == SRC_MANUAL)
            next_ho_word = FREQ_W'(manual_holdover_freq);
          else if (holdover_source_select == SRC_HIST_INSTANT)
            next_ho_word = history[wr_ptr - 6'h01 - holdover_average_span];
          else if (holdover_source_select == SRC_HIST_AVG) begin
            // the entry word covers the output while the average is worked out
            next_rd_ptr = wr_ptr - 6'h01;
            next_cnt = holdover_average_span;
            next_sum = '0;
            next_state = ST_SUM;
          end
        end
      end
      ST_SUM: begin
        next_sum = sum + SUM_W'(history[rd_ptr]);
        next_rd_ptr = rd_ptr - 6'h01;
        next_cnt = cnt - 6'h01;
        if (cnt == 6'h00) begin
          next_start = 1'b1;
          next_state = ST_DIVIDE;
        end
      end
      ST_DIVIDE: begin
        if (div.done) begin
          next_ho_word = div.quot;
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (holdover_source_select == SRC_MANUAL)
          next_ho_word = FREQ_W'(manual_holdover_freq);
      end
    endcase
    if (!holdover) next_state = ST_TRACK;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_TRACK;
      wr_ptr <= '0;
      rd_ptr <= '0;
      cnt <= '0;
      sum <= '0;
      ho_word <= '0;
      start <= 1'b0;
    end else begin
      state <= next_state;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      cnt <= next_cnt;
      sum <= next_sum;
      ho_word <= next_ho_word;
      start <= next_start;
    end
  end

  // history storage has no reset; unwritten slots are undefined until filled
  always_ff @(posedge clk) begin
    if (hist_we) history[wr_ptr] <= filt_word;
  end
endmodule

// ==== tb/holdover_monitor.sv ====
// port-level checker for the holdover / slope limit block
`timescale 1ns/10ps
module holdover_monitor
  import holdover_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [7:0] reg_rdata,
  input wire logic upd_tick,
  input wire logic holdover,
  input wire logic signed [ERR_W-1:0] meas_err,
  input wire logic [DENOMINATOR_WIDTH-1:0] frac_residue,
  input wire logic signed [ERR_W-1:0] corrected_err,
  input wire logic signed [FREQ_W-1:0] freq_out,
  input wire logic signed [PHASE_W-1:0] phase_step,
  input wire logic holdover_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================================
  // sequences
  sequence s_wr_slope;
    reg_wr && reg_addr == ADDR_SLOPE ##1 !reg_wr && reg_addr == ADDR_SLOPE;
  endsequence
  // four quiet cycles let the three-cycle register-write-to-output lag settle before stability is judged
  sequence s_hold_quiet;
    (holdover_ready && !reg_wr) [*4];
  endsequence
  sequence s_track_quiet;
    (!holdover && !upd_tick) [*4];
  endsequence
  // ==========================================================================
  // assertions
  rdata_write_a: assert property (s_wr_slope |=> reg_rdata == $past(reg_wdata, 2))
    else $error("slope byte readback differs from write");
  rdata_unmapped_a: assert property (!($past(reg_addr) inside {[ADDR_SLOPE:16'h01df]})
    |-> reg_rdata == 8'h00) else $error("unmapped address read nonzero");
  step_hold_a: assert property (!upd_tick |=> $stable(phase_step) && $stable(corrected_err))
    else $error("update outputs moved without tick");
  corr_exact_a: assert property (upd_tick && frac_residue == 24'h0 |=>
    corrected_err == $past(meas_err)) else $error("corrected error wrong at zero residue");
  freq_hold_a: assert property (s_hold_quiet |-> $stable(freq_out))
    else $error("holdover word moved");
  track_hold_a: assert property (s_track_quiet |-> $stable(freq_out))
    else $error("frequency moved without tick");
  ready_drop_a: assert property (!holdover |=> !holdover_ready)
    else $error("ready stayed after holdover release");
  ready_entry_a: assert property ($rose(holdover) |-> ##[1:130] (holdover_ready || !holdover))
    else $error("holdover word not ready in time");
endmodule

// ==== tb/tb.sv ====
// directed testbench for the holdover / slope limit block
`timescale 1ns/10ps
module tb
  import holdover_pkg::*;
;
  logic clk = 0, sys_rst = 1, reg_wr = 0, upd_tick = 0, sec_tick = 0, holdover = 0, ref_sel = 0;
  logic [15:0] reg_addr = 16'h0;
  logic [7:0] reg_wdata = 8'h0;
  logic signed [ERR_W-1:0] meas_err = 0;
  logic [DENOMINATOR_WIDTH-1:0] frac_residue = 0;
  logic [7:0] reg_rdata;
  logic signed [ERR_W-1:0] corrected_err;
  logic signed [FREQ_W-1:0] freq_out;
  logic signed [PHASE_W-1:0] phase_step;
  logic holdover_ready;
  int fail_count = 0, n_tests = 0, cycles = 0;
  holdover_slope_limit u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .upd_tick(upd_tick),
    .sec_tick(sec_tick), .holdover(holdover), .ref_sel(ref_sel), .meas_err(meas_err),
    .frac_residue(frac_residue), .corrected_err(corrected_err), .freq_out(freq_out),
    .phase_step(phase_step), .holdover_ready(holdover_ready));
  initial begin
    forever #12.5 clk = ~clk;
  end
  // ==========================================================================
  // tasks
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [47:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      reg_addr = a + 16'(i);
      reg_wdata = v[8*i +: 8];
      reg_wr = 1;
      @(negedge clk);
      reg_wr = 0;
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask
  task automatic tick(input logic signed [ERR_W-1:0] e, input logic [23:0] r, input int n);
    repeat (n) begin
      @(negedge clk);
      meas_err = e;
      frac_residue = r;
      upd_tick = 1;
      @(negedge clk);
      upd_tick = 0;
    end
    repeat (3) @(negedge clk);
  endtask
  task automatic ho_wait();
    @(negedge clk);
    holdover = 1;
    for (int i = 0; i < 200 && holdover_ready !== 1'b1; i++) @(negedge clk);
    repeat (3) @(negedge clk);
  endtask
  function automatic logic [7:0] rst_byte(input logic [15:0] a);
    case (a)
      16'h01cc, 16'h01cd, 16'h01ce, 16'h01d0, 16'h01d1, 16'h01d2: return 8'hff;
      16'h01cf, 16'h01d3: return 8'h7f;
      16'h01d4: return {SHIFT_RST, GAIN_RST};
      16'h01dc, 16'h01de: return 8'h23;
      default: return 8'h00;
    endcase
  endfunction
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  // ==========================================================================
  // main sequence
  initial begin
    repeat (10) @(negedge clk);
    sys_rst = 0;
    for (int a = 16'h01cc; a <= 16'h01df; a++) rd(16'(a), rst_byte(16'(a)));
    // every non-averaging mode answers one cycle after entry
    for (int m = 0; m < 3; m++) begin
      wr(ADDR_MODE, 48'(m << 6), 1);
      @(negedge clk);
      holdover = 1;
      chk(holdover_ready, 1'b0);
      @(negedge clk);
      chk(holdover_ready, 1'b1);
      if (m < 2) holdover = 0;
    end
    repeat (2) @(negedge clk);
    chk(freq_out, 0);
    wr(ADDR_SLOPE, 48'd50, 4);
    wr(ADDR_SCALE0, 48'h100, 2);
    tick(24'sd100, 24'h800000, 2);
    chk(corrected_err, 228);
    chk(phase_step, 50);
    ref_sel = 1;
    tick(-24'sd100, 24'h800000, 2);
    chk(corrected_err, -83);
    chk(phase_step, -50);
    tick(24'sd30, 24'h0, 2);
    chk(phase_step, 30);
    wr(ADDR_MANUAL, 48'h123, 6);
    repeat (3) @(negedge clk);
    chk(freq_out, 48'h123);
    wr(ADDR_MANUAL, 48'h3fffffffffe, 6);
    repeat (3) @(negedge clk);
    chk(freq_out, -2);
    holdover = 0;
    // zero gain bypasses the filter so the frozen word is the saturated integrator
    wr(ADDR_MODE, 48'h0, 1);
    wr(ADDR_FILT, 48'h40, 1);
    wr(ADDR_PULL, 48'h1, 4);
    tick(24'sh7fffff, 24'h0, 8);
    chk(freq_out, 1024);
    ho_wait();
    tick(-24'sh7fffff, 24'h0, 4);
    chk(freq_out, 1024);
    holdover = 0;
    tick(-24'sh7fffff, 24'h0, 8);
    chk(freq_out, -1024);
    repeat (4) begin
      @(negedge clk) sec_tick = 1;
      @(negedge clk) sec_tick = 0;
    end
    tick(24'sh7fffff, 24'h0, 8);
    @(negedge clk) sec_tick = 1;
    @(negedge clk) sec_tick = 0;
    wr(ADDR_MODE, 48'hc4, 1);
    ho_wait();
    chk(freq_out, -614);
    holdover = 0;
    wr(ADDR_MODE, 48'hc0, 1);
    ho_wait();
    chk(freq_out, 1024);
    holdover = 0;
    // history-instant with span 4 picks the sample four slots behind the newest one
    wr(ADDR_MODE, 48'h44, 1);
    ho_wait();
    chk(freq_out, -1024);
    holdover = 0;
    // shift 31, gain 4 gives a quarter step per update, applied one update after the integrator
    wr(ADDR_FILT, 48'hfc, 1);
    tick(-24'sh7fffff, 24'h0, 3);
    wr(ADDR_MODE, 48'h0, 1);
    ho_wait();
    chk(freq_out, 512);
    holdover = 0;
    wr(16'h01e0, 48'h5a, 1);
    rd(16'h01e0, 8'h00);
    wr(16'h01dd, 48'hff, 1);
    rd(16'h01dd, 8'h3f);
    wr(16'h01db, 48'hff, 1);
    rd(16'h01db, 8'h03);
    end_sim();
  end
endmodule
bind holdover_slope_limit holdover_monitor u_mon (.clk(clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
  .upd_tick(upd_tick), .holdover(holdover), .meas_err(meas_err), .frac_residue(frac_residue),
  .corrected_err(corrected_err), .freq_out(freq_out), .phase_step(phase_step),
  .holdover_ready(holdover_ready));
